// ---- include/ivr_pkg.sv ----
// Function
// - Sources 29..38 get vectors two words apart: comparator, ADC, EEPROM, timer3, TWI, store.
// - Boot reset fuse 0 starts at boot loader address, 1 starts at 0x0000.
// - Vector select set: vector address is table address plus boot section start.
// - Vector select clear: table starts at 0x0002 whatever the boot reset fuse.
// - Boot section start comes from the boot size fuses.
// - Change enable clears four cycles after arming or when vector select written.
// - Interrupts masked from arming until after the instruction following the select write.
// - Without a select write, masking lasts four cycles and then releases.
// - Sequence masking never touches the global interrupt enable flag.
// - Boot vectors with application lock programmed block interrupts in application code.
// - Application vectors with loader lock programmed block interrupts in loader code.
// - Control holds select bit 1, enable bit 0; bits 7,4 kept; others zero.
package ivr_pkg;

  localparam int ADDR_W = 16;
  localparam int VNUM_W = 6;
  localparam int NSRC = 10;

  // APB byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LASTVEC = 8'h08;

  // Control register fields
  localparam int CTRL_CE_BIT = 0;
  localparam int CTRL_SEL_BIT = 1;
  localparam int CTRL_PULLUP_BIT = 4;
  localparam int CTRL_DBG_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_RW_MASK = 8'h90;

  // Vector map
  localparam logic [VNUM_W-1:0] FIRST_VEC = 6'h1D;
  localparam logic [ADDR_W-1:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [ADDR_W-1:0] TABLE_OFS = 16'h0002;

  // Boot section starts per size fuse code, word addresses
  localparam logic [ADDR_W-1:0] BOOT_START_0 = 16'hF000;
  localparam logic [ADDR_W-1:0] BOOT_START_1 = 16'hF800;
  localparam logic [ADDR_W-1:0] BOOT_START_2 = 16'hFC00;
  localparam logic [ADDR_W-1:0] BOOT_START_3 = 16'hFE00;

  // Change window length in cycles
  localparam int CHG_WINDOW_CYC = 4;

  typedef enum logic [1:0] {
    CG_IDLE,
    CG_ARMED,
    CG_HOLD
  } ivr_cg_state_t;

endpackage

// ---- core/ivr_boot_map.sv ----
`timescale 1ns/100ps
module ivr_boot_map
  import ivr_pkg::*;
#(
  parameter logic [ADDR_W-1:0] START_0 = BOOT_START_0,
  parameter logic [ADDR_W-1:0] START_1 = BOOT_START_1,
  parameter logic [ADDR_W-1:0] START_2 = BOOT_START_2,
  parameter logic [ADDR_W-1:0] START_3 = BOOT_START_3
)
(
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_reset_fuse,
  output logic [ivr_pkg::ADDR_W-1:0] boot_start,
  output logic [ivr_pkg::ADDR_W-1:0] reset_addr
);

  always_comb
  begin
    case (boot_size_fuses)
      2'h0: boot_start = START_0;
      2'h1: boot_start = START_1;
      2'h2: boot_start = START_2;
      default: boot_start = START_3;
    endcase
  end

  always_comb
  begin
    reset_addr = boot_reset_fuse ? APP_RESET_ADDR : boot_start;
  end

endmodule

// ---- core/ivr_change_guard.sv ----
`timescale 1ns/100ps
module ivr_change_guard
  import ivr_pkg::*;
#(
  parameter int WINDOW = CHG_WINDOW_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic arm,
  input wire logic sel_write,
  input wire logic instr_retire,
  output logic window_open,
  output logic masked
);

  ivr_cg_state_t state_ff;
  ivr_cg_state_t nxt_state;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;

  localparam logic [2:0] LAST_CNT = 3'(WINDOW - 1);

  // auto clear / release after window
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      CG_IDLE:
      begin
        if (arm)
        begin
          nxt_state = CG_ARMED;
          nxt_cnt = 3'h0;
        end
      end
      CG_ARMED:
      begin
        if (sel_write)
          nxt_state = CG_HOLD;
        else if (arm)
          nxt_cnt = 3'h0;
        else if (cnt_ff == LAST_CNT)
          nxt_state = CG_IDLE;
        else
          nxt_cnt = cnt_ff + 3'h1;
      end
      CG_HOLD:
      begin
        if (instr_retire)
          nxt_state = CG_IDLE;
      end
      default: nxt_state = CG_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= CG_IDLE;
      cnt_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  assign window_open = (state_ff == CG_ARMED);
  assign masked = (state_ff != CG_IDLE) || arm;

endmodule

// ---- core/ivr_top.sv ----
`timescale 1ns/100ps
module ivr_top
  import ivr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  input wire logic boot_reset_fuse,
  input wire logic [1:0] boot_size_fuses,
  input wire logic app_section_lock,
  input wire logic loader_section_lock,
  input wire logic [ivr_pkg::ADDR_W-1:0] exec_pc,
  input wire logic instr_retire,
  input wire logic [ivr_pkg::NSRC-1:0] irq_pending,
  output logic [ivr_pkg::ADDR_W-1:0] reset_addr_ff,
  output logic irq_req_ff,
  output logic [ivr_pkg::VNUM_W-1:0] irq_vec_num_ff,
  output logic [ivr_pkg::ADDR_W-1:0] irq_vec_addr_ff,
  output logic irq_masked_ff,
  output logic vec_in_boot_ff,
  output logic pullup_disable_ff,
  output logic debug_port_disable_ff
);

  import ivr_pkg::*;

  // Base table address of a vector number, two words per entry
  function automatic logic [ADDR_W-1:0] vec_base(input logic [VNUM_W-1:0] num);
    logic [VNUM_W-1:0] idx;
    idx = num - 6'h01;
    vec_base = {9'h000, idx, 1'b0};
  endfunction

  // Lowest pending source wins
  function automatic logic [VNUM_W-1:0] pick_vec(input logic [NSRC-1:0] pend);
    logic [VNUM_W-1:0] res;
    res = FIRST_VEC;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (pend[i])
        res = FIRST_VEC + VNUM_W'(i);
    end
    pick_vec = res;
  endfunction

  logic [ADDR_W-1:0] boot_start;
  logic [ADDR_W-1:0] reset_addr;
  logic window_open;
  logic seq_masked;

  logic sel_ff;
  logic pullup_ff;
  logic dbg_ff;
  logic [7:0] ctrl_rd;

  logic setup_ph;
  logic wr_take;
  logic ctrl_wr;
  logic arm;
  logic sel_write;
  logic addr_ok;

  logic in_boot_code;
  logic lock_block;
  logic irq_allowed;
  logic [VNUM_W-1:0] pick_num;
  logic [ADDR_W-1:0] pick_addr;

  logic [VNUM_W-1:0] last_num_ff;
  logic [31:0] rd_mux;

  ivr_boot_map u_boot_map (
    .boot_size_fuses(boot_size_fuses),
    .boot_reset_fuse(boot_reset_fuse),
    .boot_start(boot_start),
    .reset_addr(reset_addr)
  );

  ivr_change_guard u_guard (
    .pclk(pclk),
    .presetn(presetn),
    .arm(arm),
    .sel_write(sel_write),
    .instr_retire(instr_retire),
    .window_open(window_open),
    .masked(seq_masked)
  );

  // APB decode
  assign setup_ph = psel && !penable;
  assign wr_take = psel && penable && pready_ff && pwrite;
  assign addr_ok = (paddr == OFS_CTRL) || (paddr == OFS_STATUS)
    || (paddr == OFS_LASTVEC);
  assign ctrl_wr = wr_take && (paddr == OFS_CTRL);

  // software arms with enable bit one
  assign arm = ctrl_wr && pwdata[CTRL_CE_BIT];

  // select accepted only in open window
  assign sel_write = ctrl_wr && !pwdata[CTRL_CE_BIT] && window_open;

  // Ready one cycle after setup: single wait-free access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_ff <= 1'b0;
    else
      pready_ff <= setup_ph;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr_ff <= 1'b0;
    else
      pslverr_ff <= setup_ph && !addr_ok;
  end

  // control readback, enable bit shows open window
  assign ctrl_rd = {dbg_ff, 2'b00, pullup_ff, 2'b00, sel_ff, window_open};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: rd_mux = {24'h00_0000, ctrl_rd};
      OFS_STATUS:
        rd_mux = {26'h000_0000, boot_size_fuses, boot_reset_fuse,
          lock_block, seq_masked, window_open};
      OFS_LASTVEC: rd_mux = {10'h000, boot_start, last_num_ff};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Sampled at setup so the value is steady through access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (setup_ph && !pwrite)
      prdata_ff <= rd_mux;
  end

  // plain read/write bits 7 and 4
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pullup_ff <= CTRL_RESET[CTRL_PULLUP_BIT];
      dbg_ff <= CTRL_RESET[CTRL_DBG_BIT];
    end
    else if (ctrl_wr)
    begin
      pullup_ff <= pwdata[CTRL_PULLUP_BIT];
      dbg_ff <= pwdata[CTRL_DBG_BIT];
    end
  end

  assign pullup_disable_ff = pullup_ff;
  assign debug_port_disable_ff = dbg_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_ff <= CTRL_RESET[CTRL_SEL_BIT];
    else if (sel_write)
      sel_ff <= pwdata[CTRL_SEL_BIT];
  end

  assign vec_in_boot_ff = sel_ff;

  // reset target, retaken from the fuses on every clock after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_addr_ff <= APP_RESET_ADDR;
    else
      reset_addr_ff <= reset_addr;
  end

  assign in_boot_code = (exec_pc >= boot_start);
  assign lock_block = (sel_ff && app_section_lock && !in_boot_code)
    || (!sel_ff && loader_section_lock && in_boot_code);

  // separate gate, global enable flag untouched
  assign irq_allowed = !seq_masked && !lock_block;

  assign pick_num = pick_vec(irq_pending);

  assign pick_addr = sel_ff ? (vec_base(pick_num) + boot_start) : vec_base(pick_num);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_req_ff <= 1'b0;
    else
      irq_req_ff <= irq_allowed && (|irq_pending);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_vec_num_ff <= FIRST_VEC;
      irq_vec_addr_ff <= TABLE_OFS;
    end
    else if (|irq_pending)
    begin
      irq_vec_num_ff <= pick_num;
      irq_vec_addr_ff <= pick_addr;
    end
  end

  // Last vector offered, for software debug
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_num_ff <= 6'h00;
    else if (irq_allowed && (|irq_pending))
      last_num_ff <= pick_num;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_masked_ff <= 1'b0;
    else
      irq_masked_ff <= !irq_allowed;
  end

endmodule

// ---- dv/ivr_monitor.sv ----
`timescale 1ns/100ps
module ivr_monitor
  import ivr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  input wire logic app_section_lock,
  input wire logic loader_section_lock,
  input wire logic irq_req_ff,
  input wire logic [ivr_pkg::VNUM_W-1:0] irq_vec_num_ff,
  input wire logic [ivr_pkg::ADDR_W-1:0] irq_vec_addr_ff,
  input wire logic irq_masked_ff,
  input wire logic vec_in_boot_ff
);
  wire ctrl_w = psel && penable && pready_ff && pwrite && paddr == 8'h00;
  wire arm_w = ctrl_w && pwdata[0];
  logic [2:0] arm_age_ff;
  // Window age 1..4 on the edges after arming; 0 once it must be closed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      arm_age_ff <= 3'h0;
    else if (arm_w)
      arm_age_ff <= 3'h1;
    else if (arm_age_ff == 3'(CHG_WINDOW_CYC))
      arm_age_ff <= 3'h0;
    else if (arm_age_ff != 3'h0)
      arm_age_ff <= arm_age_ff + 3'h1;
  end
  wire sel_w = ctrl_w && !pwdata[0] && (arm_age_ff != 3'h0);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  pready_next_a: assert property (psel && !penable |=> pready_ff)
    else $error("pready missing after setup");
  pready_once_a: assert property (pready_ff |=> !pready_ff)
    else $error("pready longer than one cycle");
  err_unmapped_a: assert property (psel && !penable && paddr > 8'h08 |=> pslverr_ff)
    else $error("unmapped access without error");
  vec_range_a: assert property (irq_req_ff |-> irq_vec_num_ff inside {[6'h1D:6'h26]})
    else $error("vector number out of range");
  app_addr_a: assert property (irq_req_ff && !vec_in_boot_ff && !$past(vec_in_boot_ff)
    |-> irq_vec_addr_ff == 16'({irq_vec_num_ff - 6'h01, 1'b0}))
    else $error("application vector address wrong");
  sel_cause_a: assert property ($changed(vec_in_boot_ff) |-> $past(sel_w))
    else $error("select bit moved without write");
  arm_mask_a: assert property (arm_w |=> (irq_masked_ff && !irq_req_ff)[*3])
    else $error("arming did not mask");
  mask_free_a: assert property (arm_w ##1
    (!ctrl_w && !app_section_lock && !loader_section_lock)[*6] |-> !irq_masked_ff)
    else $error("mask not released");
  cover property (arm_w);
  cover property (sel_w);
  cover property ($rose(vec_in_boot_ff));
  cover property (pslverr_ff);
endmodule
bind ivr_top ivr_monitor mon (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff),
  .app_section_lock(app_section_lock),
  .loader_section_lock(loader_section_lock),
  .irq_req_ff(irq_req_ff),
  .irq_vec_num_ff(irq_vec_num_ff),
  .irq_vec_addr_ff(irq_vec_addr_ff),
  .irq_masked_ff(irq_masked_ff),
  .vec_in_boot_ff(vec_in_boot_ff)
);

// ---- dv/ivr_core_model.sv ----
`timescale 1ns/100ps
module ivr_core_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic [ivr_pkg::ADDR_W-1:0] pc_in,
  output logic [ivr_pkg::ADDR_W-1:0] exec_pc,
  output logic instr_retire
);
  logic [1:0] cnt_ff;
  // Slow core on purpose, so the post-write hold is visible
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff <= 2'h0;
      instr_retire <= 1'b0;
      exec_pc <= 16'h0000;
    end
    else
    begin
      cnt_ff <= cnt_ff + 2'h1;
      instr_retire <= !stall && cnt_ff == 2'h3;
      exec_pc <= pc_in;
    end
  end
endmodule

// ---- dv/ivr_top_test.sv ----
`timescale 1ns/100ps
module ivr_top_test
  import ivr_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready_ff, pslverr_ff, err, stall;
  logic boot_reset_fuse, app_section_lock, loader_section_lock, instr_retire;
  logic irq_req_ff, irq_masked_ff, vec_in_boot_ff, pullup_disable_ff, debug_port_disable_ff;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_ff, rd;
  logic [1:0] boot_size_fuses;
  logic [ADDR_W-1:0] exec_pc, pc_in, reset_addr_ff, irq_vec_addr_ff;
  logic [VNUM_W-1:0] irq_vec_num_ff;
  logic [NSRC-1:0] irq_pending;
  int fails, n_compared;
  ivr_top dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata_ff(prdata_ff),
    .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff),
    .boot_reset_fuse(boot_reset_fuse),
    .boot_size_fuses(boot_size_fuses),
    .app_section_lock(app_section_lock),
    .loader_section_lock(loader_section_lock),
    .exec_pc(exec_pc),
    .instr_retire(instr_retire),
    .irq_pending(irq_pending),
    .reset_addr_ff(reset_addr_ff),
    .irq_req_ff(irq_req_ff),
    .irq_vec_num_ff(irq_vec_num_ff),
    .irq_vec_addr_ff(irq_vec_addr_ff),
    .irq_masked_ff(irq_masked_ff),
    .vec_in_boot_ff(vec_in_boot_ff),
    .pullup_disable_ff(pullup_disable_ff),
    .debug_port_disable_ff(debug_port_disable_ff)
  );
  ivr_core_model core (
    .pclk(pclk),
    .presetn(presetn),
    .stall(stall),
    .pc_in(pc_in),
    .exec_pc(exec_pc),
    .instr_retire(instr_retire)
  );
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen at a rising edge; only the watchdog ends a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_ff !== 1'b1);
    err = pslverr_ff;
    rd = prdata_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    fails++;
    report_and_stop;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, stall, boot_reset_fuse} = 6'h00;
    {app_section_lock, loader_section_lock} = 2'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    boot_size_fuses = 2'h1;
    pc_in = 16'h0000;
    irq_pending = 10'h000;
    fails = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(reset_addr_ff, 32'h0000F800);
    boot_reset_fuse <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(reset_addr_ff, 32'h0);
    boot_reset_fuse <= 1'b0;
    boot_size_fuses <= 2'h0;
    repeat (2) @(posedge pclk);
    chk(reset_addr_ff, 32'(BOOT_START_0));
    boot_size_fuses <= 2'h3;
    repeat (2) @(posedge pclk);
    chk(reset_addr_ff, 32'(BOOT_START_3));
    boot_size_fuses <= 2'h1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFS_CTRL, 32'hFFFFFFFE);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h90);
    chk({debug_port_disable_ff, pullup_disable_ff, vec_in_boot_ff}, 32'h6);
    for (int i = 0; i < 10; i++)
    begin
      irq_pending <= 10'h001 << i;
      repeat (3) @(posedge pclk);
      chk({irq_req_ff, irq_vec_num_ff}, 32'h5D + i);
      chk(irq_vec_addr_ff, 32'h38 + 2 * i);
    end
    irq_pending <= 10'h280;
    repeat (3) @(posedge pclk);
    chk({irq_req_ff, irq_vec_num_ff}, 32'h64);
    chk(irq_vec_addr_ff, 32'h46);
    irq_pending <= 10'h001;
    stall <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h91);
    apb(1'b1, OFS_CTRL, 32'h92);
    @(negedge pclk);
    chk({vec_in_boot_ff, irq_masked_ff, irq_req_ff}, 32'h6);
    repeat (6) @(posedge pclk);
    chk(irq_masked_ff, 32'h1);
    @(posedge pclk);
    stall <= 1'b0;
    repeat (12) @(posedge pclk);
    chk({irq_masked_ff, irq_req_ff}, 32'h1);
    chk(irq_vec_addr_ff, 32'hF838);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h92);
    apb(1'b1, OFS_CTRL, 32'h91);
    repeat (8) @(posedge pclk);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h92);
    chk(irq_masked_ff, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h90);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h92);
    app_section_lock <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({irq_masked_ff, irq_req_ff}, 32'h2);
    pc_in <= 16'hF900;
    repeat (4) @(posedge pclk);
    chk({irq_masked_ff, irq_req_ff}, 32'h1);
    app_section_lock <= 1'b0;
    loader_section_lock <= 1'b1;
    apb(1'b1, OFS_CTRL, 32'h91);
    apb(1'b1, OFS_CTRL, 32'h90);
    repeat (12) @(posedge pclk);
    chk({vec_in_boot_ff, irq_masked_ff, irq_req_ff}, 32'h2);
    pc_in <= 16'h0100;
    repeat (4) @(posedge pclk);
    chk({irq_req_ff, irq_vec_addr_ff}, 32'h10038);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, OFS_LASTVEC, 32'h0);
    chk(rd, 32'h003E001D);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    chk(err, 32'h1);
    report_and_stop;
  end
endmodule
